// [rtl/mas_sequencer.sv]
// Chosen here: register access over APB and the register offsets.
`timescale 1ns/1ns
`include "mas_consts.svh"

module mas_sequencer #(
    parameter logic [31:0] ANS_MIN_CYC = 32'(`MAS_ANS_MIN_CYC),
    parameter logic [31:0] ANS_MAX_CYC = 32'(`MAS_ANS_MAX_CYC),
    parameter logic [31:0] DISC_MIN_CYC = 32'(`MAS_DISC_MIN_CYC),
    parameter logic [31:0] DISC_MAX_CYC = 32'(`MAS_DISC_MAX_CYC),
    parameter logic [31:0] OFF_CYC = 32'(`MAS_OFF_CYC)
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Service request to the host
    output logic srq,
    // Automatic calling unit
    input wire logic acu_next_digit,
    input wire logic acu_abandon,
    input wire logic data_set_status_line,
    input wire logic acu_digit_ready,
    output logic call_request_line,
    output logic [3:0] acu_digit,
    output logic acu_digit_valid,
    // Data set
    input wire logic ds_ready,
    input wire logic line_occupied,
    output logic terminal_ready
);

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [5:0] sync1_reg, sync2_reg;
    logic pnd_prev_reg;
    logic pnd_s, abandon_s, dss_s, dig_rdy_s, dsr_s, occ_s;

    // Two flops on every pin, read at the second stage; the next-digit pin also feeds a third flop for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_reg <= 6'h00;
            sync2_reg <= 6'h00;
            pnd_prev_reg <= 1'b0;
        end else begin
            sync1_reg <= {acu_next_digit, acu_abandon, data_set_status_line,
                          acu_digit_ready, ds_ready, line_occupied};
            sync2_reg <= sync1_reg;
            pnd_prev_reg <= sync2_reg[5];
        end
    end

    assign pnd_s = sync2_reg[5];
    assign abandon_s = sync2_reg[4];
    assign dss_s = sync2_reg[3];
    assign dig_rdy_s = sync2_reg[2];
    assign dsr_s = sync2_reg[1];
    assign occ_s = sync2_reg[0];

    ////////////////////////////////////////////////////////////////////////////
    // APB slave

    // Only the low address byte is decoded
    function automatic mas_pkg::mas_sel_t addr_sel(input logic [31:0] a);
        if (a[7:0] == `MAS_OFF_CMD) addr_sel = mas_pkg::SEL_CMD;
        else if (a[7:0] == `MAS_OFF_DATA) addr_sel = mas_pkg::SEL_DATA;
        else if (a[7:0] == `MAS_OFF_STAT) addr_sel = mas_pkg::SEL_STAT;
        else if (a[7:0] == `MAS_OFF_CTRL) addr_sel = mas_pkg::SEL_CTRL;
        else addr_sel = mas_pkg::SEL_NONE;
    endfunction : addr_sel

    mas_pkg::mas_sel_t sel;
    logic pready_reg, pready_next, pslverr_reg, pslverr_next;
    logic [31:0] prdata_reg, prdata_next;
    logic ctrl_reg, ctrl_next;
    logic acc_wait, commit, wr_cmd, wr_data, rd_stat, buf_push, buf_in_ready;
    logic [31:0] status_word;
    mas_pkg::mas_cmd_t cmd;
    mas_pkg::mas_state_t state_reg, state_next;
    logic srq_reg, abandon_reg, crq_reg, dtr_reg;

    assign sel = addr_sel(paddr);
    assign acc_wait = psel & penable & ~pready_reg;
    assign commit = psel & penable & pready_reg;
    assign wr_cmd = commit & pwrite & (sel == mas_pkg::SEL_CMD);
    assign wr_data = commit & pwrite & (sel == mas_pkg::SEL_DATA);
    assign rd_stat = commit & ~pwrite & (sel == mas_pkg::SEL_STAT);
    assign buf_push = wr_data;
    assign cmd = mas_pkg::mas_cmd_t'(pwdata[`MAS_CMD_MSB:0]);

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`MAS_ST_OCC] = occ_s;
        status_word[`MAS_ST_ABANDON] = abandon_reg;
        status_word[`MAS_ST_DSS] = dss_s;
        status_word[`MAS_ST_DSR] = dsr_s;
        status_word[`MAS_ST_SRQ] = srq_reg;
        status_word[`MAS_ST_STATE_LSB +: 3] = state_reg;
    end

    // Answer one cycle into the access phase; a digit write stalls while
    // the buffer is full, so a slow calling unit never loses a digit
    always_comb begin
        pready_next = acc_wait & ~(pwrite & (sel == mas_pkg::SEL_DATA) & ~buf_in_ready);
        pslverr_next = acc_wait & (sel == mas_pkg::SEL_NONE);
        prdata_next = prdata_reg;
        if (acc_wait & ~pwrite) begin
            if (sel == mas_pkg::SEL_STAT) prdata_next = status_word;
            else if (sel == mas_pkg::SEL_CTRL) prdata_next = {31'h0000_0000, ctrl_reg};
            else prdata_next = 32'h0000_0000;
        end
        ctrl_next = ctrl_reg;
        if (commit & pwrite & (sel == mas_pkg::SEL_CTRL)) ctrl_next = pwdata[`MAS_CTRL_DSOPT];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
            ctrl_reg <= `MAS_CTRL_RST;
        end else begin
            pready_reg <= pready_next;
            pslverr_reg <= pslverr_next;
            prdata_reg <= prdata_next;
            ctrl_reg <= ctrl_next;
        end
    end

    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign prdata = prdata_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Digit path to the calling unit

    mas_buf #(.W(4)) u_buf (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(buf_push),
        .in_ready(buf_in_ready),
        .in_data(pwdata[`MAS_DIGIT_MSB:`MAS_DIGIT_LSB]),
        .out_valid(acu_digit_valid),
        .out_ready(dig_rdy_s),
        .out_data(acu_digit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Call sequencer

    logic [31:0] tmr_reg, tmr_next;
    logic srq_next, abandon_next, crq_next, dtr_next, srq_set, busy;

    assign busy = occ_s | dsr_s;

    always_comb begin
        state_next = state_reg;
        abandon_next = abandon_reg;
        crq_next = crq_reg;
        dtr_next = dtr_reg;
        srq_set = 1'b0;
        // Line-side progress
        case (state_reg)
            mas_pkg::ST_DIALING: begin
                if (pnd_s & ~pnd_prev_reg) srq_set = 1'b1;
            end
            mas_pkg::ST_WAIT_ANS: begin
                if (tmr_reg >= ANS_MIN_CYC && (dsr_s | abandon_s)) begin
                    srq_set = 1'b1;
                    abandon_next = ~dsr_s;
                    state_next = dsr_s ? mas_pkg::ST_CONNECTED : mas_pkg::ST_IDLE;
                end else if (tmr_reg >= ANS_MAX_CYC) begin
                    srq_set = 1'b1;
                    abandon_next = 1'b1;
                    state_next = mas_pkg::ST_IDLE;
                end
            end
            mas_pkg::ST_DISC_WAIT: begin
                if ((tmr_reg >= DISC_MIN_CYC && !occ_s && !dss_s)
                    || tmr_reg >= DISC_MAX_CYC) begin
                    srq_set = 1'b1;
                    state_next = mas_pkg::ST_IDLE;
                end
            end
            mas_pkg::ST_OFF_WAIT: begin
                if (tmr_reg >= OFF_CYC) begin
                    srq_set = 1'b1;
                    state_next = mas_pkg::ST_IDLE;
                end
            end
            default: begin
            end
        endcase
        // Host commands take priority over line progress
        if (wr_cmd) begin
            case (cmd)
                mas_pkg::CMD_TERM_READY: dtr_next = 1'b1;
                mas_pkg::CMD_CALL_REQUEST: begin
                    if (dtr_reg && !busy && !crq_reg && state_reg == mas_pkg::ST_IDLE) begin
                        crq_next = 1'b1;
                        abandon_next = 1'b0;
                        state_next = mas_pkg::ST_DIALING;
                    end
                end
                mas_pkg::CMD_DIAL_DONE: begin
                    if (state_reg == mas_pkg::ST_DIALING) state_next = mas_pkg::ST_WAIT_ANS;
                end
                mas_pkg::CMD_ENABLE_DISC: begin
                    if (crq_reg) begin
                        crq_next = 1'b0;
                        abandon_next = 1'b0;
                        if (!(ctrl_reg && state_reg == mas_pkg::ST_CONNECTED))
                            state_next = mas_pkg::ST_DISC_WAIT;
                    end
                end
                mas_pkg::CMD_TERM_OFF: begin
                    dtr_next = 1'b0;
                    state_next = mas_pkg::ST_OFF_WAIT;
                end
                default: begin
                end
            endcase
        end
        tmr_next = (state_next != state_reg) ? 32'h0000_0000 : tmr_reg + 32'h0000_0001;
        srq_next = srq_set | (srq_reg & ~(rd_stat | wr_data));
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= mas_pkg::ST_IDLE;
            tmr_reg <= 32'h0000_0000;
            srq_reg <= 1'b0;
            abandon_reg <= 1'b0;
            crq_reg <= 1'b0;
            dtr_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            tmr_reg <= tmr_next;
            srq_reg <= srq_next;
            abandon_reg <= abandon_next;
            crq_reg <= crq_next;
            dtr_reg <= dtr_next;
        end
    end

    assign srq = srq_reg;
    assign call_request_line = crq_reg;
    assign terminal_ready = dtr_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    chk_busy_flag: assert property (
        (acc_wait && !pwrite && sel == mas_pkg::SEL_STAT) |=> prdata[`MAS_ST_OCC] == $past(occ_s))
        else $error("occupied flag wrong");

    chk_dsr_flag: assert property (
        (acc_wait && !pwrite && sel == mas_pkg::SEL_STAT) |=> prdata[`MAS_ST_DSR] == $past(dsr_s))
        else $error("data set ready flag wrong");

    chk_busy_ignore: assert property (
        (wr_cmd && cmd == mas_pkg::CMD_CALL_REQUEST && busy && !crq_reg) |=> !call_request_line)
        else $error("call request taken while busy");

    chk_digit_srq: assert property (
        (state_reg == mas_pkg::ST_DIALING && pnd_s && !pnd_prev_reg) |=> srq)
        else $error("digit request not raised");

    chk_digit_bits: assert property (
        (wr_data && !acu_digit_valid) |=> acu_digit_valid && acu_digit == $past(pwdata[7:4]))
        else $error("digit not forwarded");

    chk_ans_window: assert property (
        (state_reg == mas_pkg::ST_WAIT_ANS && state_next != mas_pkg::ST_WAIT_ANS && !wr_cmd)
        |-> tmr_reg >= ANS_MIN_CYC && tmr_reg <= ANS_MAX_CYC)
        else $error("answer request outside window");

    chk_abandon_drop: assert property (
        (wr_cmd && cmd == mas_pkg::CMD_ENABLE_DISC && abandon_reg && crq_reg)
        |=> !call_request_line && state_reg == mas_pkg::ST_DISC_WAIT)
        else $error("call request not cancelled");

    chk_disc_window: assert property (
        (state_reg == mas_pkg::ST_DISC_WAIT && state_next == mas_pkg::ST_IDLE)
        |-> tmr_reg >= DISC_MIN_CYC && tmr_reg <= DISC_MAX_CYC)
        else $error("disconnect request outside window");

    chk_incoming_kept: assert property (
        (wr_cmd && cmd == mas_pkg::CMD_ENABLE_DISC && !crq_reg
         && state_reg == mas_pkg::ST_CONNECTED) |=> state_reg == mas_pkg::ST_CONNECTED)
        else $error("disconnect ended unplaced call");

    chk_off_delay: assert property (
        (state_reg == mas_pkg::ST_OFF_WAIT && state_next == mas_pkg::ST_IDLE)
        |-> tmr_reg == OFF_CYC ##1 srq)
        else $error("terminal off request mistimed");

    chk_srq_hold: assert property (
        (srq && !rd_stat && !wr_data) |=> srq)
        else $error("service request dropped early");

    cov_good_call: cover property (
        state_reg == mas_pkg::ST_WAIT_ANS ##1 state_reg == mas_pkg::ST_CONNECTED);
    // Abandon flag is cleared by the disconnect itself, so look one cycle back
    cov_failed_call: cover property (abandon_reg ##1 state_reg == mas_pkg::ST_DISC_WAIT);
    cov_digit_stall: cover property (acc_wait && pwrite && !buf_in_ready);
    cov_term_off: cover property (state_reg == mas_pkg::ST_OFF_WAIT ##1 srq);

endmodule : mas_sequencer

// [rtl/mas_consts.svh]
`ifndef MAS_CONSTS_SVH
`define MAS_CONSTS_SVH

// Register byte offsets, low address byte only
`define MAS_OFF_CMD 8'h00
`define MAS_OFF_DATA 8'h04
`define MAS_OFF_STAT 8'h08
`define MAS_OFF_CTRL 8'h0C

// Command code field
`define MAS_CMD_MSB 2
// Dial digit field, weight 8 at bit 7 down to weight 1 at bit 4
`define MAS_DIGIT_MSB 7
`define MAS_DIGIT_LSB 4
// Status word bit positions
`define MAS_ST_OCC 7
`define MAS_ST_ABANDON 6
`define MAS_ST_DSS 4
`define MAS_ST_DSR 0
`define MAS_ST_SRQ 8
`define MAS_ST_STATE_LSB 9
// Control bit: 1 selects release by the data set
`define MAS_CTRL_DSOPT 0
`define MAS_CTRL_RST 1'b0

// Timing, clock in kHz and times in ms
`define MAS_CLK_KHZ 25_000
`define MAS_ANS_MIN_MS 200
`define MAS_ANS_MAX_MS 40_000
`define MAS_DISC_MIN_MS 175
`define MAS_DISC_MAX_MS 1_000
`define MAS_OFF_MS 150
`define MAS_ANS_MIN_CYC (`MAS_ANS_MIN_MS * `MAS_CLK_KHZ)
`define MAS_ANS_MAX_CYC (`MAS_ANS_MAX_MS * `MAS_CLK_KHZ)
`define MAS_DISC_MIN_CYC (`MAS_DISC_MIN_MS * `MAS_CLK_KHZ)
`define MAS_DISC_MAX_CYC (`MAS_DISC_MAX_MS * `MAS_CLK_KHZ)
`define MAS_OFF_CYC (`MAS_OFF_MS * `MAS_CLK_KHZ)

`endif

// [rtl/mas_pkg.sv]
package mas_pkg;

    // Call sequencing states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DIALING = 3'b001,
        ST_WAIT_ANS = 3'b010,
        ST_CONNECTED = 3'b011,
        ST_DISC_WAIT = 3'b100,
        ST_OFF_WAIT = 3'b101
    } mas_state_t;

    // Command codes written to the command register
    typedef enum logic [2:0] {
        CMD_NONE = 3'b000,
        CMD_TERM_READY = 3'b001,
        CMD_CALL_REQUEST = 3'b010,
        CMD_DIAL_DONE = 3'b011,
        CMD_ENABLE_DISC = 3'b100,
        CMD_TERM_OFF = 3'b101
    } mas_cmd_t;

    // Register select
    typedef enum logic [2:0] {
        SEL_NONE = 3'b000,
        SEL_CMD = 3'b001,
        SEL_DATA = 3'b010,
        SEL_STAT = 3'b011,
        SEL_CTRL = 3'b100
    } mas_sel_t;

endpackage : mas_pkg

// [rtl/mas_buf.sv]
`timescale 1ns/1ns

module mas_buf #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Filling side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Draining side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);

    logic v0_reg, v0_next, v1_reg, v1_next;
    logic [W-1:0] d0_reg, d0_next, d1_reg, d1_next;
    logic pop, push;

    // Entry 0 is always the head, so outputs come straight from flops
    always_comb begin
        pop = v0_reg & out_ready;
        push = in_valid & ~v1_reg;
        v0_next = v0_reg;
        v1_next = v1_reg;
        d0_next = d0_reg;
        d1_next = d1_reg;
        if (pop) begin
            v0_next = v1_reg;
            d0_next = d1_reg;
            v1_next = 1'b0;
        end
        if (push) begin
            if (!v0_next) begin
                v0_next = 1'b1;
                d0_next = in_data;
            end else begin
                v1_next = 1'b1;
                d1_next = in_data;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            v0_reg <= 1'b0;
            v1_reg <= 1'b0;
            d0_reg <= '0;
            d1_reg <= '0;
        end else begin
            v0_reg <= v0_next;
            v1_reg <= v1_next;
            d0_reg <= d0_next;
            d1_reg <= d1_next;
        end
    end

    // Ready only while the second slot is free: full is honest
    assign in_ready = ~v1_reg;
    assign out_valid = v0_reg;
    assign out_data = d0_reg;

endmodule : mas_buf

// [tb/mas_acu_model.sv]
`timescale 1ns/1ns

module mas_acu_model (
    // Clock
    input wire logic pclk,
    // Bench controls
    input wire logic busy,
    input wire logic ab_mode,
    input wire logic [3:0] n_dig,
    input wire logic [7:0] stall,
    // Sequencer side
    input wire logic call_request_line,
    input wire logic terminal_ready,
    input wire logic [3:0] acu_digit,
    input wire logic acu_digit_valid,
    output logic acu_next_digit,
    output logic acu_abandon,
    output logic data_set_status_line,
    output logic acu_digit_ready,
    output logic ds_ready,
    output logic line_occupied,
    // Digits taken, for the bench
    output logic dig_stb,
    output logic [3:0] dig_val
);
    int got = 0;
    int b;
    int k;
    logic occ_c = 1'b0;
    logic dsr_c = 1'b0;

    // An incoming call shows the line busy and the data set ready
    assign line_occupied = busy | occ_c;
    assign ds_ready = busy | dsr_c;

    ////////////////////////////////////////////////////////////////////////////////
    // Short ready pulses, spaced wider than the sync, so one pulse takes one digit
    // digit taken whole
    initial begin
        acu_digit_ready = 1'b0;
        dig_stb = 1'b0;
        dig_val = 4'h0;
        forever begin
            @(posedge pclk);
            if (acu_digit_valid === 1'b1) begin
                repeat (stall + $urandom_range(0, 3)) @(posedge pclk);
                acu_digit_ready <= 1'b1;
                dig_stb <= 1'b1;
                dig_val <= acu_digit;
                got++;
                @(posedge pclk);
                acu_digit_ready <= 1'b0;
                dig_stb <= 1'b0;
                repeat (4) @(posedge pclk);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Dialing, answer and release of one call
    initial begin
        acu_next_digit = 1'b0;
        acu_abandon = 1'b0;
        data_set_status_line = 1'b0;
        forever begin
            @(posedge call_request_line);
            b = got;
            // ask only once the buffer ran dry
            while (got - b < n_dig) begin
                k = got;
                @(posedge pclk);
                acu_next_digit <= 1'b1;
                repeat (3) @(posedge pclk);
                acu_next_digit <= 1'b0;
                wait (got > k);
                repeat (6) @(posedge pclk);
                wait (acu_digit_valid !== 1'b1);
            end
            repeat (30) @(posedge pclk);
            if (ab_mode) begin
                acu_abandon <= 1'b1;
            end else begin
                occ_c <= 1'b1;
                dsr_c <= 1'b1;
                data_set_status_line <= 1'b1;
            end
            wait (!call_request_line || !terminal_ready);
            repeat (5) @(posedge pclk);
            occ_c <= 1'b0;
            dsr_c <= 1'b0;
            data_set_status_line <= 1'b0;
            acu_abandon <= 1'b0;
        end
    end
endmodule : mas_acu_model

// [tb/modem_autocall_sequencer_tb.sv]
`timescale 1ns/1ns
`include "mas_consts.svh"

module modem_autocall_sequencer_tb;
    typedef struct {logic [31:0] d; logic [31:0] m; logic e;} mas_rd_t;
    localparam int ANS_MIN = 20;
    localparam int ANS_MAX = 200;
    localparam int DISC_MIN = 15;
    localparam int DISC_MAX = 100;
    localparam int OFF_CYC = 12;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, srq;
    logic [31:0] paddr, pwdata, prdata;
    logic acu_next_digit, acu_abandon, data_set_status_line, acu_digit_ready;
    logic call_request_line, acu_digit_valid, ds_ready, line_occupied, terminal_ready;
    logic busy, ab_mode, dig_stb;
    logic [3:0] acu_digit, dig_val, n_dig;
    logic [7:0] stall;
    mas_rd_t q_rd[$];
    logic [3:0] q_dig[$];
    int n_errors = 0;
    int n_checks = 0;
    int c;

    mas_sequencer #(
        .ANS_MIN_CYC(32'(ANS_MIN)), .ANS_MAX_CYC(32'(ANS_MAX)),
        .DISC_MIN_CYC(32'(DISC_MIN)), .DISC_MAX_CYC(32'(DISC_MAX)), .OFF_CYC(32'(OFF_CYC))
    ) u_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .srq, .acu_next_digit, .acu_abandon, .data_set_status_line,
        .acu_digit_ready, .call_request_line, .acu_digit, .acu_digit_valid, .ds_ready,
        .line_occupied, .terminal_ready
    );

    mas_acu_model u_acu (
        .pclk, .busy, .ab_mode, .n_dig, .stall, .call_request_line, .terminal_ready,
        .acu_digit, .acu_digit_valid, .acu_next_digit, .acu_abandon, .data_set_status_line,
        .acu_digit_ready, .ds_ready, .line_occupied, .dig_stb, .dig_val
    );

    // Clock, 40 ns period
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t read %h expected %h", $time, g, e);
        end
    endtask : cmp_word

    task automatic cmp_flag(input logic g, input logic e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t flag %b expected %b", $time, g, e);
        end
    endtask : cmp_flag

    task automatic cmp_digit(input logic [3:0] g, input logic [3:0] e);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR t=%0t digit %h expected %h", $time, g, e);
        end
    endtask : cmp_digit

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : conclude

    ////////////////////////////////////////////////////////////////////////////////
    // One transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [31:0] m,
                      input logic e);
        q_rd.push_back('{d, m, e});
        apb(1'b0, a, $urandom);
    endtask : rd

    task automatic cmd(input mas_pkg::mas_cmd_t x);
        apb(1'b1, `MAS_OFF_CMD, 32'(x));
    endtask : cmd

    // Bounded wait for a service request, counted in falling edges; a request
    // that rises k edges after the returning transfer's commit edge gives k+1
    task automatic wait_srq(output int n);
        n = 0;
        do begin
            @(negedge pclk);
            n++;
        end while (srq !== 1'b1 && n < 3000);
    endtask : wait_srq

    task automatic gap(input int n);
        repeat (n) @(negedge pclk);
    endtask : gap

    // Places a call; burst fills the digit buffer while the unit stalls
    task automatic call(input logic ab, input int nd, input logic burst, input logic ds);
        int w;
        int t0;
        logic [3:0] d;
        cmd(mas_pkg::CMD_TERM_READY);
        ab_mode <= ab;
        n_dig <= 4'(nd);
        stall <= burst ? 8'h28 : 8'h02;
        cmd(mas_pkg::CMD_CALL_REQUEST);
        gap(2);
        cmp_flag(call_request_line, 1'b1);
        w = 0;
        while (w < nd) begin
            wait_srq(c);
            for (int i = 0; i < ((w == 0 && burst) ? 3 : 1); i++) begin
                d = 4'($urandom_range(0, 9));
                q_dig.push_back(d);
                t0 = $time;
                apb(1'b1, `MAS_OFF_DATA, {24'h00_0000, d, 4'h0});
                if (i == 2) cmp_flag(($time - t0) > 400, 1'b1);
                w++;
            end
        end
        cmd(mas_pkg::CMD_DIAL_DONE);
        wait_srq(c);
        cmp_flag(c >= ANS_MIN && c <= ANS_MAX, 1'b1);
        rd(`MAS_OFF_STAT, ab ? 32'h0000_0040 : 32'h0000_0691, 32'h0000_0EFF, 1'b0);
        gap(1);
        cmp_flag(srq, 1'b0);
        cmd(mas_pkg::CMD_ENABLE_DISC);
        if (ds) begin
            cmd(mas_pkg::CMD_ENABLE_DISC);
            cmd(mas_pkg::CMD_TERM_OFF);
            wait_srq(c);
            cmp_flag(c == OFF_CYC + 2, 1'b1);
            cmp_flag(terminal_ready, 1'b0);
        end else begin
            wait_srq(c);
            cmp_flag(c >= DISC_MIN && c <= DISC_MAX, 1'b1);
        end
        cmp_flag(call_request_line, 1'b0);
        rd(`MAS_OFF_STAT, 32'h0000_0000, 32'h0000_00D1, 1'b0);
    endtask : call

    ////////////////////////////////////////////////////////////////////////////////
    // Read results and taken digits are matched against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && q_rd.size() > 0) begin
            cmp_word(prdata & q_rd[0].m, q_rd[0].d);
            cmp_flag(pslverr, q_rd[0].e);
            void'(q_rd.pop_front());
        end
        if (dig_stb === 1'b1 && q_dig.size() > 0) begin
            cmp_digit(dig_val, q_dig.pop_front());
        end
    end

    // Watchdog, far beyond the expected run of under a thousand cycles
    initial begin
        repeat (30000) @(posedge pclk);
        n_errors++;
        $display("ERROR t=%0t watchdog expired", $time);
        conclude();
    end

    // Main sequence
    initial begin
        void'($urandom(32'hfa84));
        presetn = 1'b0;
        {psel, penable, pwrite, busy, ab_mode} = 5'h00;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        n_dig = 4'h0;
        stall = 8'h00;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        cmp_flag(terminal_ready | call_request_line | srq, 1'b0);
        rd(`MAS_OFF_STAT, 32'h0000_0000, 32'h0000_0FFF, 1'b0);
        rd(8'h10, 32'h0000_0000, 32'hFFFF_FFFF, 1'b1);
        rd(`MAS_OFF_CTRL, 32'h0000_0000, 32'h0000_0001, 1'b0);
        cmd(mas_pkg::CMD_TERM_READY);
        busy <= 1'b1;
        gap(3);
        rd(`MAS_OFF_STAT, 32'h0000_0081, 32'h0000_00FF, 1'b0);
        cmd(mas_pkg::CMD_CALL_REQUEST);
        cmd(mas_pkg::CMD_ENABLE_DISC);
        gap(30);
        cmp_flag(call_request_line | srq, 1'b0);
        cmp_flag(terminal_ready, 1'b1);
        @(posedge pclk);
        busy <= 1'b0;
        cmd(mas_pkg::CMD_TERM_OFF);
        wait_srq(c);
        cmp_flag(c == OFF_CYC + 2, 1'b1);
        rd(`MAS_OFF_STAT, 32'h0000_0000, 32'h0000_00FF, 1'b0);
        call(1'b0, 4, 1'b1, 1'b0);
        call(1'b1, 2, 1'b0, 1'b0);
        apb(1'b1, `MAS_OFF_CTRL, 32'h0000_0001);
        rd(`MAS_OFF_CTRL, 32'h0000_0001, 32'h0000_0001, 1'b0);
        call(1'b0, 3, 1'b0, 1'b1);
        gap(2);
        cmp_flag(q_dig.size() == 0 && q_rd.size() == 0, 1'b1);
        conclude();
    end
endmodule : modem_autocall_sequencer_tb
